// ==== cib_bridge.sv ====
`timescale 1ns/1ps
// Behaviour
// - a state is one active clock edge to the next; cycles are 2 or 3 states
// - ROM and RAM take two states over 16 bits, byte or word
// - peripherals use an 8-bit path, byte only, two or three states
// - ROM decodes from zero to a variant top address
// - serial buffer FF80-FF9F is byte only, two states
// - timer windows F770-F77F and FFB8-FFBD take three states, other I/O two
// - writes to unassigned space are dropped, reads return undefined data
// - word write to I/O stores only the upper byte
// - word read from I/O puts the byte in the upper half, lower undefined
// - interrupt exception uses the stack pointer and pushes PC and condition codes
// - reset, execute, halt and exception states; execute on system or subclock
// - halt has sleep, standby, watch, subsleep; no instructions execute
// - bit instructions read the byte, change one bit, write the byte back
// - shared timer address reads the counter and writes the load register
// - port data reads pins for inputs and the latch for outputs
// - a write-only register reads back as all ones
module cib_bridge
	import cib_pkg::*;
#(
	parameter logic [15:0] ROM_TOP = ROM_TOP_60K
) (
	// clock, reset, active-clock enable
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// cpu access port
	input wire cib_req_t cpu_req_in,
	output logic cpu_ready_out,
	output cib_rsp_t cpu_rsp_out,
	// cpu state control
	input wire logic sub_mode_in,
	input wire logic halt_req_in,
	input wire cib_halt_t halt_mode_in,
	input wire logic wake_in,
	input wire logic irq_in,
	input wire logic [15:0] irq_pc_in,
	input wire logic [7:0] irq_ccr_in,
	input wire logic [15:0] stack_pointer_in,
	output cib_cpu_t cpu_state_out,
	output cib_halt_t halt_mode_out,
	output logic exec_en_out,
	output logic sub_clk_sel_out,
	output logic excp_done_out,
	output logic [15:0] stack_pointer_out,
	// on-chip memory bus
	output cib_mbus_t mem_out,
	input wire logic [15:0] mem_rdata_in,
	// peripheral bus
	output cib_pbus_t per_out,
	input wire logic [7:0] per_rdata_in,
	// port pins
	input wire logic [7:0] port_pin_in,
	output logic [7:0] port_pin_out,
	output logic [7:0] port_pin_oe_out
);

	cib_state_t st_ff;
	cib_state_t nxt_st;

	// memory map decode
	function automatic cib_region_t decode(input logic [15:0] a);
		if (a <= ROM_TOP) begin
			decode = RG_ROM;
		end else if (a >= RAM_LO && a <= RAM_HI) begin
			decode = RG_RAM;
		end else if (a >= SDB_LO && a <= SDB_HI) begin
			decode = RG_SDB;
		end else if ((a >= IO1_LO && a <= IO1_HI) || (a >= IO2_LO && a <= IO2_HI)) begin
			decode = RG_IO;
		end else begin
			decode = RG_NONE;
		end
	endfunction

	// timer windows stretch the cycle to three states
	function automatic logic is_slow(input logic [15:0] a);
		is_slow = (a >= TMRX_LO && a <= TMRX_HI) || (a >= TMRV_LO && a <= TMRV_HI);
	endfunction

	// registers served here rather than on the peripheral bus
	function automatic logic is_local(input logic [15:0] a);
		is_local = (a == PORT_DATA_ADDR) || (a == PORT_DIR_ADDR) || (a == TMR_ADDR);
	endfunction

	// single-bit alteration for the bit instructions
	function automatic logic [7:0] bit_mod(input logic [7:0] b, input cib_bop_t op,
			input logic [2:0] n, input logic c);
		logic [7:0] m;
		m = 8'(9'h001 << n);
		case (op)
			BO_SET: bit_mod = b | m;
			BO_CLR: bit_mod = b & ~m;
			BO_NOT: bit_mod = b ^ m;
			BO_ST: bit_mod = c ? (b | m) : (b & ~m);
			BO_IST: bit_mod = c ? (b & ~m) : (b | m);
			default: bit_mod = b;
		endcase
	endfunction

	logic acc;
	logic last;
	logic accept;
	logic go;
	cib_req_t greq;
	logic [7:0] io_byte;
	logic [7:0] wr_byte;
	logic [15:0] rd_word;

	assign acc = (st_ff.ph == BP_ACC);
	assign last = acc && (st_ff.cnt == 2'h1);
	// interrupt and halt requests take the bus slot ahead of a new access
	assign cpu_ready_out = (st_ff.cs == CS_EXEC) && !acc && !irq_in && !halt_req_in;
	assign accept = ce_in && cpu_ready_out && cpu_req_in.valid;

	// byte seen on the 8-bit side
	always_comb begin
		if (st_ff.req.addr == PORT_DATA_ADDR) begin
			io_byte = (st_ff.dat & st_ff.dir) | (st_ff.pins & ~st_ff.dir);
		end else if (st_ff.req.addr == PORT_DIR_ADDR) begin
			io_byte = WO_READ;
		end else if (st_ff.req.addr == TMR_ADDR) begin
			io_byte = st_ff.tcnt;
		end else begin
			io_byte = per_rdata_in;
		end
	end

	// read data as the cpu register sees it
	always_comb begin
		wr_byte = st_ff.req.word ? st_ff.req.wdata[15:8] : st_ff.req.wdata[7:0];
		case (st_ff.rg)
			RG_ROM, RG_RAM: begin
				if (st_ff.req.word) begin
					rd_word = mem_rdata_in;
				end else begin
					rd_word = {8'h00, st_ff.req.addr[0] ? mem_rdata_in[7:0] : mem_rdata_in[15:8]};
				end
			end
			RG_SDB, RG_IO: begin
				rd_word = st_ff.req.word ? {io_byte, UNDEF_BYTE} : {8'h00, io_byte};
			end
			default: rd_word = UNDEF_WORD;
		endcase
	end

	// next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rsp.done = 1'b0;
		nxt_st.excp_done = 1'b0;
		go = 1'b0;
		greq = cpu_req_in;
		if (ce_in) begin
			// pin synchroniser: a change counts once stages two and three agree
			nxt_st.sync = {st_ff.sync[1], st_ff.sync[0], port_pin_in};
			if (st_ff.sync[1] == st_ff.sync[2]) begin
				nxt_st.pins = st_ff.sync[2];
			end
			// reloadable timer counts one per state
			nxt_st.tcnt = (st_ff.tcnt == TMR_TOP) ? st_ff.tload : 8'(st_ff.tcnt + 8'h01);
			// top-level cpu states
			case (st_ff.cs)
				CS_RESET: begin
					nxt_st.cs = CS_EXCP;
					nxt_st.push = PUSH_NONE;
				end
				CS_EXEC: begin
					nxt_st.sub = sub_mode_in;
					if (!acc && irq_in) begin
						nxt_st.cs = CS_EXCP;
						nxt_st.push = PUSH_PC;
						nxt_st.pc = irq_pc_in;
						nxt_st.condition_code_reg = irq_ccr_in;
						nxt_st.sp = stack_pointer_in;
					end else if (!acc && halt_req_in) begin
						nxt_st.cs = CS_HALT;
						nxt_st.hm = halt_mode_in;
					end else if (accept) begin
						go = 1'b1;
					end
				end
				CS_HALT: begin
					if (irq_in) begin
						nxt_st.cs = CS_EXCP;
						nxt_st.push = PUSH_PC;
						nxt_st.pc = irq_pc_in;
						nxt_st.condition_code_reg = irq_ccr_in;
						nxt_st.sp = stack_pointer_in;
					end else if (wake_in) begin
						nxt_st.cs = CS_EXEC;
					end
				end
				CS_EXCP: begin
					if (!acc) begin
						if (st_ff.push == PUSH_NONE) begin
							nxt_st.cs = CS_EXEC;
							nxt_st.excp_done = 1'b1;
						end else begin
							// stack pushes use the normal word write path
							go = 1'b1;
							greq.valid = 1'b1;
							greq.wr = 1'b1;
							greq.word = 1'b1;
							greq.bop = BO_NONE;
							greq.addr = 16'(st_ff.sp - SP_STEP);
							greq.wdata = (st_ff.push == PUSH_PC) ? st_ff.pc : {st_ff.condition_code_reg, st_ff.condition_code_reg};
						end
					end
				end
				default: nxt_st.cs = CS_RESET;
			endcase
			// bit instructions always move a single byte
			if (greq.bop != BO_NONE) begin
				greq.word = 1'b0;
				greq.wr = 1'b0;
			end
			if (go) begin
				nxt_st.req = greq;
				nxt_st.rg = decode(greq.addr);
				nxt_st.slow = is_slow(greq.addr) && (decode(greq.addr) == RG_IO);
				nxt_st.cnt = nxt_st.slow ? STATES_SLOW : STATES_FAST;
				nxt_st.ph = BP_ACC;
			end else if (acc && !last) begin
				nxt_st.cnt = 2'(st_ff.cnt - 2'h1);
			end else if (last) begin
				if (st_ff.req.wr && st_ff.rg == RG_IO) begin
					if (st_ff.req.addr == PORT_DATA_ADDR) begin
						nxt_st.dat = wr_byte;
					end
					if (st_ff.req.addr == PORT_DIR_ADDR) begin
						nxt_st.dir = wr_byte;
					end
					if (st_ff.req.addr == TMR_ADDR) begin
						nxt_st.tload = wr_byte;
					end
				end
				if (!st_ff.req.wr && st_ff.req.bop != BO_NONE) begin
					// read done: rerun the cycle as a write of the altered byte
					nxt_st.req.wr = 1'b1;
					nxt_st.req.wdata = {8'h00, bit_mod(rd_word[7:0], st_ff.req.bop,
						st_ff.req.bitno, st_ff.req.cbit)};
					nxt_st.req.bop = BO_NONE;
					nxt_st.cnt = st_ff.slow ? STATES_SLOW : STATES_FAST;
				end else begin
					nxt_st.ph = BP_IDLE;
					if (st_ff.cs == CS_EXCP) begin
						nxt_st.push = 2'(st_ff.push - 2'h1);
						nxt_st.sp = st_ff.req.addr;
					end else begin
						nxt_st.rsp.done = 1'b1;
						nxt_st.rsp.rdata = st_ff.req.wr ? st_ff.rsp.rdata : rd_word;
					end
				end
			end
		end
	end

	// state register; clock enable low freezes everything except the done and exception-exit pulses, which clear
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_ff <= '{ph: BP_IDLE, cnt: 2'h0, req: '0, rg: RG_NONE, slow: 1'b0, rsp: '0,
				cs: CS_RESET, hm: HM_SLEEP, sub: 1'b0, excp_done: 1'b0, push: PUSH_NONE,
				pc: 16'h0000, condition_code_reg: 8'h00, sp: SP_RST, dat: PORT_RST, dir: DIR_RST,
				tload: TMR_RST, tcnt: TMR_RST, sync: '0, pins: 8'h00};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// memory bus: ROM writes and unassigned space never strobe
	always_comb begin
		mem_out.rom_sel = acc && (st_ff.rg == RG_ROM);
		mem_out.ram_sel = acc && (st_ff.rg == RG_RAM);
		mem_out.we = acc && st_ff.req.wr && (st_ff.rg == RG_RAM);
		mem_out.commit = last && (st_ff.rg == RG_ROM || st_ff.rg == RG_RAM);
		mem_out.be = st_ff.req.word ? 2'h3 : (st_ff.req.addr[0] ? 2'h1 : 2'h2);
		mem_out.addr = st_ff.req.word ? {st_ff.req.addr[15:1], 1'b0} : st_ff.req.addr;
		mem_out.wdata = st_ff.req.word ? st_ff.req.wdata : {2{st_ff.req.wdata[7:0]}};
	end

	// peripheral bus carries a single byte
	always_comb begin
		per_out.sel = acc && (st_ff.rg == RG_IO || st_ff.rg == RG_SDB) &&
			!is_local(st_ff.req.addr);
		per_out.we = per_out.sel && st_ff.req.wr;
		per_out.commit = per_out.sel && last;
		per_out.slow = st_ff.slow;
		per_out.addr = st_ff.req.addr;
		per_out.wdata = wr_byte;
	end

	// remaining outputs straight from state
	assign cpu_rsp_out = st_ff.rsp;
	assign cpu_state_out = st_ff.cs;
	assign halt_mode_out = st_ff.hm;
	assign exec_en_out = (st_ff.cs == CS_EXEC);
	assign sub_clk_sel_out = st_ff.sub;
	assign excp_done_out = st_ff.excp_done;
	assign stack_pointer_out = st_ff.sp;
	assign port_pin_out = st_ff.dat;
	assign port_pin_oe_out = st_ff.dir;

	// fast regions load two states
	property p_fast_cnt;
		@(posedge core_clk_in) disable iff (rst_in)
		(go && !is_slow(greq.addr)) |=> (st_ff.cnt == 2'h2);
	endproperty
	a_fast_cnt: assert property (p_fast_cnt) else $error("fast access not two states");

	// timer windows load three states
	property p_slow_cnt;
		@(posedge core_clk_in) disable iff (rst_in)
		(go && is_slow(greq.addr) && decode(greq.addr) == RG_IO) |=> (st_ff.cnt == 2'h3);
	endproperty
	a_slow_cnt: assert property (p_slow_cnt) else $error("timer access not three states");

	// an answer only follows a final state
	property p_done_after_last;
		@(posedge core_clk_in) disable iff (rst_in)
		cpu_rsp_out.done |-> $past(last && ce_in);
	endproperty
	a_done_after_last: assert property (p_done_after_last) else $error("answer without cycle");

	// unassigned space never strobes a write
	property p_unmapped_quiet;
		@(posedge core_clk_in) disable iff (rst_in)
		(acc && st_ff.rg == RG_NONE) |-> (!mem_out.we && !per_out.we && !per_out.sel);
	endproperty
	a_unmapped_quiet: assert property (p_unmapped_quiet) else $error("unmapped write");

	// word write to I/O drives the upper byte
	property p_word_io_upper;
		@(posedge core_clk_in) disable iff (rst_in)
		(per_out.we && st_ff.req.word) |-> (per_out.wdata == st_ff.req.wdata[15:8]);
	endproperty
	a_word_io_upper: assert property (p_word_io_upper) else $error("wrong I/O byte");

	// direction register reads as all ones
	property p_wo_read;
		@(posedge core_clk_in) disable iff (rst_in)
		(ce_in && last && !st_ff.req.wr && st_ff.req.bop == BO_NONE && !st_ff.req.word &&
			st_ff.cs == CS_EXEC && st_ff.req.addr == PORT_DIR_ADDR)
			|=> (cpu_rsp_out.rdata == 16'h00FF);
	endproperty
	a_wo_read: assert property (p_wo_read) else $error("write-only read not FF");

	// bit instruction read turns into a write to the same address
	property p_rmw_write;
		@(posedge core_clk_in) disable iff (rst_in)
		(ce_in && last && !st_ff.req.wr && st_ff.req.bop != BO_NONE)
			|=> (acc && st_ff.req.wr && st_ff.req.addr == $past(st_ff.req.addr));
	endproperty
	a_rmw_write: assert property (p_rmw_write) else $error("bit op lost its write");

	// halt state accepts no access
	property p_halt_idle;
		@(posedge core_clk_in) disable iff (rst_in)
		(st_ff.cs == CS_HALT) |-> (!cpu_ready_out && !exec_en_out);
	endproperty
	a_halt_idle: assert property (p_halt_idle) else $error("access during halt");

	// interrupt entry pushes the program counter first, below the stack pointer
	property p_push_pc;
		@(posedge core_clk_in) disable iff (rst_in)
		(go && st_ff.cs == CS_EXCP && st_ff.push == PUSH_PC)
			|=> (st_ff.req.wdata == $past(st_ff.pc) && st_ff.req.addr == 16'($past(st_ff.sp) - SP_STEP));
	endproperty
	a_push_pc: assert property (p_push_pc) else $error("bad program counter push");

endmodule // cib_bridge

// ==== cib_mem_model.sv ====
`timescale 1ns/1ps
module cib_mem_model
	import cib_pkg::*;
(
	// clock and active-clock enable
	input wire logic core_clk_in,
	input wire logic ce_in,
	// 16-bit memory side
	input wire cib_mbus_t mem_in,
	output logic [15:0] mem_rdata_out,
	// 8-bit peripheral side
	input wire cib_pbus_t per_in,
	output logic [7:0] per_rdata_out
);
	logic [7:0] mem_ff [0:65535];
	logic [7:0] per_ff [0:255];
	logic [15:0] last_mem_ff;
	logic [7:0] last_per_ff;
	logic [15:0] wa;
	// rom and ram preload with a pattern the bench can predict
	initial begin
		for (int i = 0; i < 65536; i++) mem_ff[i] = 8'(i) ^ 8'(i >> 8);
		for (int i = 0; i < 256; i++) per_ff[i] = 8'h00;
		last_mem_ff = 16'h0000;
		last_per_ff = 8'h00;
	end
	assign wa = {mem_in.addr[15:1], 1'b0};
	// released bus shows the inverse of the last value, never a stale match
	assign mem_rdata_out = (mem_in.rom_sel | mem_in.ram_sel) ?
		{mem_ff[wa], mem_ff[wa | 16'h0001]} : ~last_mem_ff;
	assign per_rdata_out = per_in.sel ? per_ff[per_in.addr[7:0]] : ~last_per_ff;
	// data lands on the commit edge only; rom ignores writes like the real array
	always @(posedge core_clk_in) begin
		if (ce_in && mem_in.commit && (mem_in.rom_sel || mem_in.ram_sel)) begin
			last_mem_ff <= mem_rdata_out;
			if (mem_in.we && mem_in.ram_sel && mem_in.be[1]) mem_ff[wa] <= mem_in.wdata[15:8];
			if (mem_in.we && mem_in.ram_sel && mem_in.be[0]) mem_ff[wa | 16'h0001] <= mem_in.wdata[7:0];
		end
		if (ce_in && per_in.commit && per_in.sel) begin
			last_per_ff <= per_rdata_out;
			if (per_in.we) per_ff[per_in.addr[7:0]] <= per_in.wdata;
		end
	end
endmodule // cib_mem_model

// ==== cib_pkg.sv ====
package cib_pkg;

	// memory map boundaries
	localparam logic [15:0] ROM_LO = 16'h0000;
	localparam logic [15:0] ROM_TOP_60K = 16'hEDFF;
	localparam logic [15:0] ROM_TOP_48K = 16'hBFFF;
	localparam logic [15:0] ROM_TOP_40K = 16'h9FFF;
	localparam logic [15:0] ROM_TOP_32K = 16'h7FFF;
	localparam logic [15:0] IO1_LO = 16'hF740;
	localparam logic [15:0] IO1_HI = 16'hF77F;
	localparam logic [15:0] TMRX_LO = 16'hF770;
	localparam logic [15:0] TMRX_HI = 16'hF77F;
	localparam logic [15:0] RAM_LO = 16'hFB80;
	localparam logic [15:0] RAM_HI = 16'hFF7F;
	localparam logic [15:0] SDB_LO = 16'hFF80;
	localparam logic [15:0] SDB_HI = 16'hFF9F;
	localparam logic [15:0] IO2_LO = 16'hFFA0;
	localparam logic [15:0] IO2_HI = 16'hFFFF;
	localparam logic [15:0] TMRV_LO = 16'hFFB8;
	localparam logic [15:0] TMRV_HI = 16'hFFBD;

	// registers held inside this block
	localparam logic [15:0] PORT_DATA_ADDR = 16'hFFD6;
	localparam logic [15:0] PORT_DIR_ADDR = 16'hFFE6;
	localparam logic [15:0] TMR_ADDR = 16'hF772;

	// states per bus cycle
	localparam logic [1:0] STATES_FAST = 2'h2;
	localparam logic [1:0] STATES_SLOW = 2'h3;

	// reset and fixed read values
	localparam logic [7:0] WO_READ = 8'hFF;
	localparam logic [7:0] UNDEF_BYTE = 8'h00;
	localparam logic [15:0] UNDEF_WORD = 16'h0000;
	localparam logic [7:0] PORT_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] TMR_RST = 8'h00;
	localparam logic [7:0] TMR_TOP = 8'hFF;
	localparam logic [15:0] SP_STEP = 16'h0002;
	localparam logic [15:0] SP_RST = 16'h0000;

	// pending stack pushes during exception entry
	localparam logic [1:0] PUSH_NONE = 2'h0;
	localparam logic [1:0] PUSH_CCR = 2'h1;
	localparam logic [1:0] PUSH_PC = 2'h2;

	typedef enum logic [2:0] {RG_NONE, RG_ROM, RG_RAM, RG_SDB, RG_IO} cib_region_t;
	typedef enum logic [1:0] {CS_RESET, CS_EXEC, CS_HALT, CS_EXCP} cib_cpu_t;
	typedef enum logic [1:0] {HM_SLEEP, HM_STANDBY, HM_WATCH, HM_SUBSLEEP} cib_halt_t;
	typedef enum logic [2:0] {BO_NONE, BO_SET, BO_CLR, BO_NOT, BO_ST, BO_IST} cib_bop_t;
	typedef enum logic {BP_IDLE, BP_ACC} cib_phase_t;

	// cpu access request
	typedef struct packed {
		logic valid;
		logic wr;
		logic word;
		logic [15:0] addr;
		logic [15:0] wdata;
		cib_bop_t bop;
		logic [2:0] bitno;
		logic cbit;
	} cib_req_t;

	// cpu access answer
	typedef struct packed {
		logic done;
		logic [15:0] rdata;
	} cib_rsp_t;

	// 16-bit on-chip memory bus
	typedef struct packed {
		logic rom_sel;
		logic ram_sel;
		logic we;
		logic commit;
		logic [1:0] be;
		logic [15:0] addr;
		logic [15:0] wdata;
	} cib_mbus_t;

	// 8-bit peripheral bus
	typedef struct packed {
		logic sel;
		logic we;
		logic commit;
		logic slow;
		logic [15:0] addr;
		logic [7:0] wdata;
	} cib_pbus_t;

	// whole state of the bridge
	typedef struct packed {
		cib_phase_t ph;
		logic [1:0] cnt;
		cib_req_t req;
		cib_region_t rg;
		logic slow;
		cib_rsp_t rsp;
		cib_cpu_t cs;
		cib_halt_t hm;
		logic sub;
		logic excp_done;
		logic [1:0] push;
		logic [15:0] pc;
		logic [7:0] condition_code_reg;
		logic [15:0] sp;
		logic [7:0] dat;
		logic [7:0] dir;
		logic [7:0] tload;
		logic [7:0] tcnt;
		logic [2:0][7:0] sync;
		logic [7:0] pins;
	} cib_state_t;

endpackage

// ==== test_cpu_internal_bus_access.sv ====
`timescale 1ns/1ps
module test_cpu_internal_bus_access;
	import cib_pkg::*;
	localparam logic [15:0] ROM_T = ROM_TOP_48K;
	logic core_clk_in, rst_in, ce_in, ce_half, sub_mode_in, halt_req_in, wake_in, irq_in;
	logic cpu_ready_out, exec_en_out, sub_clk_sel_out, excp_done_out;
	cib_req_t cpu_req_in;
	cib_rsp_t cpu_rsp_out;
	cib_halt_t halt_mode_in, halt_mode_out;
	cib_cpu_t cpu_state_out;
	cib_mbus_t mem_out;
	cib_pbus_t per_out;
	logic [15:0] irq_pc_in, stack_pointer_in, stack_pointer_out, mem_rdata_in, rd_v;
	logic [7:0] irq_ccr_in, per_rdata_in, port_pin_in, port_pin_out, port_pin_oe_out;
	int mismatches, comparisons, excp_cnt, n_v;
	cib_bridge #(.ROM_TOP(ROM_T)) i_cib_bridge (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.ce_in(ce_in), .cpu_req_in(cpu_req_in), .cpu_ready_out(cpu_ready_out),
		.cpu_rsp_out(cpu_rsp_out), .sub_mode_in(sub_mode_in), .halt_req_in(halt_req_in),
		.halt_mode_in(halt_mode_in), .wake_in(wake_in), .irq_in(irq_in), .irq_pc_in(irq_pc_in),
		.irq_ccr_in(irq_ccr_in), .stack_pointer_in(stack_pointer_in),
		.cpu_state_out(cpu_state_out), .halt_mode_out(halt_mode_out), .exec_en_out(exec_en_out),
		.sub_clk_sel_out(sub_clk_sel_out), .excp_done_out(excp_done_out),
		.stack_pointer_out(stack_pointer_out), .mem_out(mem_out), .mem_rdata_in(mem_rdata_in),
		.per_out(per_out), .per_rdata_in(per_rdata_in), .port_pin_in(port_pin_in),
		.port_pin_out(port_pin_out), .port_pin_oe_out(port_pin_oe_out));
	cib_mem_model i_cib_mem_model (.core_clk_in(core_clk_in), .ce_in(ce_in), .mem_in(mem_out),
		.mem_rdata_out(mem_rdata_in), .per_in(per_out), .per_rdata_out(per_rdata_in));
	// free-running clock
	initial begin
		core_clk_in = 1'b0;
		forever #10 core_clk_in = ~core_clk_in;
	end
	// halved enable stands in for the slower subclock
	always @(posedge core_clk_in) ce_in <= ce_half ? ~ce_in : 1'b1;
	// count exception exits
	always @(posedge core_clk_in) if (excp_done_out === 1'b1) excp_cnt <= excp_cnt + 1;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// one cpu access; n_v counts active-clock edges from take to done
	task automatic xfer(input logic wr, input logic wd_sz, input logic [15:0] a,
		input logic [15:0] wd, input cib_bop_t bo, input logic [2:0] bn, input logic cb);
		int t;
		logic c;
		t = 0;
		n_v = 0;
		@(posedge core_clk_in);
		cpu_req_in <= '{valid: 1'b1, wr: wr, word: wd_sz, addr: a, wdata: wd, bop: bo,
			bitno: bn, cbit: cb};
		@(negedge core_clk_in);
		while (!(cpu_ready_out === 1'b1 && ce_in === 1'b1) && t < 50) begin
			@(negedge core_clk_in);
			t++;
		end
		@(posedge core_clk_in);
		cpu_req_in.valid <= 1'b0;
		t = 0;
		while (t < 50) begin
			@(negedge core_clk_in);
			if (cpu_rsp_out.done === 1'b1) break;
			c = ce_in;
			@(posedge core_clk_in);
			n_v += int'(c);
			t++;
		end
		rd_v = cpu_rsp_out.rdata;
		chk(16'(t < 50), 16'h0001);
	endtask
	task automatic wr_do(input logic w, input logic [15:0] a, input logic [15:0] d, input int st);
		xfer(1'b1, w, a, d, BO_NONE, 3'h0, 1'b0);
		chk(16'(n_v), 16'(st));
	endtask
	task automatic rd_chk(input logic w, input logic [15:0] a, input logic [15:0] e, input int st);
		xfer(1'b0, w, a, 16'h0000, BO_NONE, 3'h0, 1'b0);
		chk(rd_v, e);
		chk(16'(n_v), 16'(st));
	endtask
	task automatic wait_state(input cib_cpu_t s);
		int t;
		t = 0;
		while (cpu_state_out !== s && t < 60) begin
			@(negedge core_clk_in);
			t++;
		end
		chk(16'(cpu_state_out), 16'(s));
	endtask
	logic [15:0] hole [5] = '{16'hF73F, 16'hF780, 16'hFB7F, 16'hEE00, ROM_T + 16'h0001};
	// rom variant top, ram, unassigned holes
	task automatic t_mem;
		rd_chk(1'b0, 16'h0001, 16'h0001, 2);
		rd_chk(1'b1, ROM_T - 16'h0001, 16'h4140, 2);
		wr_do(1'b0, 16'h0010, 16'hEEEE, 2);
		rd_chk(1'b0, 16'h0010, 16'h0010, 2);
		wr_do(1'b1, 16'hFB80, 16'hA55A, 2);
		wr_do(1'b0, 16'hFF7F, 16'h3C3C, 2);
		rd_chk(1'b1, 16'hFB80, 16'hA55A, 2);
		rd_chk(1'b0, 16'hFF7F, 16'h003C, 2);
		foreach (hole[i]) begin
			wr_do(1'b0, hole[i], 16'h5555, 2);
			rd_chk(1'b0, hole[i], {8'h00, UNDEF_BYTE}, 2);
		end
	endtask
	logic [15:0] io_a [8] = '{16'hF740, 16'hF76F, 16'hF770, 16'hF77F, 16'hFFB8, 16'hFFBD,
		16'hFFBE, 16'hFF9F};
	int io_s [8] = '{2, 2, 3, 3, 3, 3, 2, 2};
	// io windows, three-state timer areas, word access to io
	task automatic t_io;
		foreach (io_a[i]) begin
			wr_do(1'b0, io_a[i], {2{io_a[i][7:0] ^ 8'hC5}}, io_s[i]);
			rd_chk(1'b0, io_a[i], {8'h00, io_a[i][7:0] ^ 8'hC5}, io_s[i]);
		end
		wr_do(1'b1, 16'hFFA0, 16'hC37E, 2);
		rd_chk(1'b0, 16'hFFA0, 16'h00C3, 2);
		rd_chk(1'b1, 16'hFFA0, {8'hC3, UNDEF_BYTE}, 2);
	endtask
	cib_bop_t bo_l [5] = '{BO_SET, BO_NOT, BO_ST, BO_IST, BO_CLR};
	logic [2:0] bn_l [5] = '{3'h3, 3'h0, 3'h1, 3'h7, 3'h4};
	logic cb_l [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [7:0] ex_l [5] = '{8'hF8, 8'hF9, 8'hFB, 8'h7B, 8'h6B};
	// every bit operation as read, modify, write back
	task automatic t_bitops;
		wr_do(1'b0, 16'hFB91, 16'hF0F0, 2);
		foreach (bo_l[i]) begin
			xfer(1'b0, 1'b0, 16'hFB91, 16'h0000, bo_l[i], bn_l[i], cb_l[i]);
			chk(16'(n_v), 16'h0004);
			rd_chk(1'b0, 16'hFB91, {8'h00, ex_l[i]}, 2);
		end
		xfer(1'b0, 1'b0, 16'hF774, 16'h0000, BO_SET, 3'h2, 1'b0);
		chk(16'(n_v), 16'h0006);
		rd_chk(1'b0, 16'hF774, 16'h0004, 3);
	endtask
	// port read mixes pins and latch; write-only direction reads all ones
	task automatic t_port;
		wr_do(1'b0, PORT_DIR_ADDR, 16'h3F3F, 2);
		rd_chk(1'b0, PORT_DIR_ADDR, {8'h00, WO_READ}, 2);
		wr_do(1'b0, PORT_DATA_ADDR, 16'h8080, 2);
		repeat (5) @(posedge core_clk_in);
		rd_chk(1'b0, PORT_DATA_ADDR, 16'h0040, 2);
		chk(16'(port_pin_oe_out), 16'h003F);
		xfer(1'b0, 1'b0, PORT_DATA_ADDR, 16'h0000, BO_SET, 3'h0, 1'b0);
		chk(16'(port_pin_out), 16'h0041);
		xfer(1'b0, 1'b0, PORT_DIR_ADDR, 16'h0000, BO_CLR, 3'h0, 1'b0);
		chk(16'(port_pin_oe_out), 16'h00FE);
		wr_do(1'b0, 16'hFB90, 16'h8080, 2);
		xfer(1'b0, 1'b0, 16'hFB90, 16'h0000, BO_SET, 3'h0, 1'b0);
		rd_chk(1'b0, 16'hFB90, 16'h0081, 2);
		wr_do(1'b0, PORT_DATA_ADDR, {2{rd_v[7:0]}}, 2);
		chk(16'(port_pin_out), 16'h0081);
	endtask
	// shared address: write loads, read shows the running count
	task automatic t_timer;
		wr_do(1'b0, TMR_ADDR, 16'hF0F0, 3);
		repeat (300) @(posedge core_clk_in);
		xfer(1'b0, 1'b0, TMR_ADDR, 16'h0000, BO_NONE, 3'h0, 1'b0);
		chk(16'(rd_v[7:0] >= 8'hF0), 16'h0001);
		chk(16'(n_v), 16'h0003);
	endtask
	// interrupt pushes pc then condition codes below the stack pointer
	task automatic t_irq;
		@(posedge core_clk_in);
		stack_pointer_in <= 16'hFF00;
		irq_pc_in <= 16'h1234;
		irq_ccr_in <= 8'h85;
		irq_in <= 1'b1;
		wait_state(CS_EXCP);
		@(posedge core_clk_in);
		irq_in <= 1'b0;
		wait_state(CS_EXEC);
		// exit pulse is tallied on the edge after it shows
		@(negedge core_clk_in);
		chk(stack_pointer_out, 16'hFEFC);
		chk(16'(excp_cnt), 16'h0002);
		rd_chk(1'b1, 16'hFEFE, 16'h1234, 2);
		rd_chk(1'b1, 16'hFEFC, 16'h8585, 2);
	endtask
	// each halt mode stops execution until wake
	task automatic t_halt;
		for (int m = 0; m < 4; m++) begin
			@(posedge core_clk_in);
			halt_req_in <= 1'b1;
			halt_mode_in <= cib_halt_t'(m);
			wait_state(CS_HALT);
			@(posedge core_clk_in);
			halt_req_in <= 1'b0;
			@(negedge core_clk_in);
			chk(16'(halt_mode_out), 16'(m));
			chk({exec_en_out, cpu_ready_out}, 16'h0000);
			@(posedge core_clk_in);
			wake_in <= 1'b1;
			@(posedge core_clk_in);
			wake_in <= 1'b0;
			wait_state(CS_EXEC);
			chk(16'(exec_en_out), 16'h0001);
		end
	endtask
	// subactive: states counted in slower active-clock edges
	task automatic t_sub;
		@(posedge core_clk_in);
		sub_mode_in <= 1'b1;
		ce_half <= 1'b1;
		wr_do(1'b1, 16'hFC00, 16'h6996, 2);
		rd_chk(1'b1, 16'hFC00, 16'h6996, 2);
		wr_do(1'b0, 16'hFFB9, 16'h7C7C, 3);
		rd_chk(1'b0, 16'hFFB9, 16'h007C, 3);
		chk(16'(sub_clk_sel_out), 16'h0001);
		@(posedge core_clk_in);
		ce_half <= 1'b0;
		sub_mode_in <= 1'b0;
	endtask
	// watchdog sized well past the expected run
	initial begin
		repeat (20000) @(posedge core_clk_in);
		mismatches++;
		finish_test();
	end
	initial begin
		mismatches = 0;
		comparisons = 0;
		excp_cnt = 0;
		{ce_in, rst_in} = 2'b11;
		{ce_half, sub_mode_in, halt_req_in, wake_in, irq_in} = 5'h00;
		cpu_req_in = '0;
		halt_mode_in = HM_SLEEP;
		irq_pc_in = 16'h0000;
		irq_ccr_in = 8'h00;
		stack_pointer_in = 16'h0000;
		port_pin_in = 8'h40;
		repeat (20) @(posedge core_clk_in);
		chk(16'(cpu_state_out), 16'(CS_RESET));
		rst_in <= 1'b0;
		wait_state(CS_EXEC);
		@(negedge core_clk_in);
		chk(16'(excp_cnt), 16'h0001);
		t_mem();
		t_io();
		t_bitops();
		t_port();
		t_timer();
		t_irq();
		t_halt();
		t_sub();
		finish_test();
	end
endmodule // test_cpu_internal_bus_access
